/* hdl/sso_axil_regs.sv */
`timescale 1ns/1ps
`include "sso_consts.svh"
// AXI4-Lite slave holding the settings; answers one cycle after both halves arrive
module sso_axil_regs (
  input  wire logic        mclk,        // Control clock
  input  wire logic        rst_n,       // Synchronous reset
  input  wire logic        ce,          // Clock enable
  input  wire logic [11:0] awaddr,      // Write address
  input  wire logic        awvalid,     // Write address valid
  output logic             awready,     // Write address ready
  input  wire logic [31:0] wdata,       // Write data
  input  wire logic [3:0]  wstrb,       // Byte strobes
  input  wire logic        wvalid,      // Write data valid
  output logic             wready,      // Write data ready
  output logic [1:0]       bresp,       // Write response
  output logic             bvalid,      // Write response valid
  input  wire logic        bready,      // Write response ready
  input  wire logic [11:0] araddr,      // Read address
  input  wire logic        arvalid,     // Read address valid
  output logic             arready,     // Read address ready
  output logic [31:0]      rdata,       // Read data
  output logic [1:0]       rresp,       // Read response
  output logic             rvalid,      // Read valid
  input  wire logic        rready,      // Read ready
  input  wire logic [2:0]  flags,       // Live indications
  output logic             modeVel,     // Velocity control mode
  output logic [15:0]      holdMs,      // Motion-condition time
  output logic [15:0]      zeroWidth,   // Zero-speed width
  output logic [15:0]      reachThr,    // Velocity-reached threshold
  output logic [15:0]      fluctRange,  // Fluctuation range
  output logic [23:0]      funcCodes    // Output functions, three bytes
);
  import sso_pkg::*;
  logic [11:0] wAddr_r;
  logic [31:0] wData_r;
  logic        haveA_r, haveD_r;

  function automatic logic [15:0] clampv(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampv

  function automatic logic known(input logic [11:0] a);
    known = (a <= `SSO_OFF_STATUS) && (a[1:0] == 2'b00);
  endfunction : known

  // Readies are flops: low from their handshake until the answer is taken
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      haveA_r <= 1'b0; haveD_r <= 1'b0; bvalid <= 1'b0; bresp <= SSO_RESP_OKAY;
      wAddr_r <= 12'h000; wData_r <= 32'h0000_0000;
      awready <= 1'b1;
      wready <= 1'b1;
    end else if (ce) begin
      if (awvalid && awready) begin
        haveA_r <= 1'b1;
        wAddr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        haveD_r <= 1'b1;
        wData_r <= wdata;
        wready <= 1'b0;
      end
      if (haveA_r && haveD_r) begin
        haveA_r <= 1'b0; haveD_r <= 1'b0; bvalid <= 1'b1;
        bresp <= known(wAddr_r) ? SSO_RESP_OKAY : SSO_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  logic [3:0] strb_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) strb_r <= 4'h0;
    else if (ce && wvalid && wready) strb_r <= wstrb;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      modeVel <= 1'b1; holdMs <= `SSO_MS_DEF; zeroWidth <= `SSO_ZW_DEF;
      reachThr <= `SSO_VV_DEF; fluctRange <= `SSO_VR_DEF; funcCodes <= 24'h00_0000;
    end else if (ce && haveA_r && haveD_r && strb_r != 4'h0) begin
      case (wAddr_r)
        `SSO_OFF_CTRL:    modeVel <= wData_r[0];
        `SSO_OFF_TIME:    holdMs <= clampv(wData_r[15:0], 16'h0000, `SSO_MS_MAX);
        `SSO_OFF_ZWIDTH:  zeroWidth <= clampv(wData_r[15:0], `SSO_ZW_MIN, `SSO_ZW_MAX);
        `SSO_OFF_VTHRESH: reachThr <= clampv(wData_r[15:0], `SSO_VV_MIN, `SSO_VV_MAX);
        `SSO_OFF_VRANGE:  fluctRange <= clampv(wData_r[15:0], `SSO_VR_MIN, `SSO_VR_MAX);
        `SSO_OFF_FUNC:    funcCodes <= wData_r[23:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rvalid <= 1'b0; rdata <= 32'h0000_0000; rresp <= SSO_RESP_OKAY;
      arready <= 1'b1;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        arready <= 1'b0;
        rresp  <= known(araddr) ? SSO_RESP_OKAY : SSO_RESP_SLVERR;
        case (araddr)
          `SSO_OFF_CTRL:    rdata <= {31'h0000_0000, modeVel};
          `SSO_OFF_TIME:    rdata <= {16'h0000, holdMs};
          `SSO_OFF_ZWIDTH:  rdata <= {16'h0000, zeroWidth};
          `SSO_OFF_VTHRESH: rdata <= {16'h0000, reachThr};
          `SSO_OFF_VRANGE:  rdata <= {16'h0000, fluctRange};
          `SSO_OFF_FUNC:    rdata <= {8'h00, funcCodes};
          `SSO_OFF_STATUS:  rdata <= {29'h0000_0000, flags};
          default:          rdata <= 32'h0000_0000;
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule : sso_axil_regs

/* hdl/sso_consts.svh */
`ifndef SSO_CONSTS_SVH
`define SSO_CONSTS_SVH
// Register byte offsets
`define SSO_OFF_CTRL     12'h000
`define SSO_OFF_TIME     12'h004
`define SSO_OFF_ZWIDTH   12'h008
`define SSO_OFF_VTHRESH  12'h00C
`define SSO_OFF_VRANGE   12'h010
`define SSO_OFF_FUNC     12'h014
`define SSO_OFF_STATUS   12'h018
// Speeds held in 0.1 rps units
`define SSO_ZW_MIN       16'h0001
`define SSO_ZW_MAX       16'h0014
`define SSO_ZW_DEF       16'h0005
`define SSO_VV_MIN       16'h0000
`define SSO_VV_MAX       16'h03E8
`define SSO_VV_DEF       16'h0064
`define SSO_VR_MIN       16'h0001
`define SSO_VR_MAX       16'h03E8
`define SSO_VR_DEF       16'h0002
// Motion-condition time in ms
`define SSO_MS_MAX       16'h7530
`define SSO_MS_DEF       16'h000A
// Output function codes
`define SSO_FN_ZS_ON     8'h16
`define SSO_FN_ZS_OFF    8'h22
`define SSO_FN_VR_ON     8'h0A
`define SSO_FN_VR_INV    8'h14
`define SSO_FN_VC_ON     8'h11
`define SSO_FN_VC_OFF    8'h12
// Clock 25 MHz, one ms tick
`define SSO_CLK_KHZ      25000
`define SSO_TICK_CYCLES  (`SSO_CLK_KHZ * 1)
`endif

/* hdl/sso_pkg.sv */
package sso_pkg;
  typedef enum logic [1:0] {SSO_RESP_OKAY = 2'b00, SSO_RESP_SLVERR = 2'b10} sso_resp_t;
  typedef logic [15:0] sso_speed_t;
endpackage : sso_pkg

/* hdl/sso_qual_timer.sv */
`timescale 1ns/1ps
`include "sso_consts.svh"
// Holds a flag once its condition has stood for the motion-condition time
module sso_qual_timer (
  input  wire logic        mclk,       // Control clock
  input  wire logic        rst_n,      // Synchronous reset
  input  wire logic        ce,         // Clock enable
  input  wire logic        msTick,     // One-ms tick
  input  wire logic        cond,       // Comparison result
  input  wire logic [15:0] holdMs,     // Qualification time
  output logic             flag        // Qualified indication
);
  logic [15:0] count_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_r <= 16'h0000;
    end else if (ce) begin
      if (!cond) count_r <= 16'h0000;
      else if (msTick && count_r < holdMs) count_r <= count_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (ce) begin
      flag <= cond && (count_r >= holdMs);
    end
  end

  qual_lapse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !cond |=> !flag) else $error("flag held after lapse");
endmodule : sso_qual_timer

/* hdl/sso_speed_status.sv */
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "sso_consts.svh"
module sso_speed_status #(
  parameter int TICK_CYCLES = `SSO_TICK_CYCLES   // Cycles per ms
) (
  input  wire logic        mclk,        // 25 MHz control clock
  input  wire logic        rst_n,       // Synchronous reset, active low
  input  wire logic        ce,          // Clock enable
  input  wire logic [15:0] actSpeed,    // Signed actual speed, 0.1 rps
  input  wire logic [15:0] filtSpeed,   // Signed filtered speed, 0.1 rps
  input  wire logic [15:0] cmdSpeed,    // Signed commanded speed, 0.1 rps
  input  wire logic [11:0] awaddr,      // AXI write address
  input  wire logic        awvalid,     // AXI write address valid
  output logic             awready,     // AXI write address ready
  input  wire logic [31:0] wdata,       // AXI write data
  input  wire logic [3:0]  wstrb,       // AXI byte strobes
  input  wire logic        wvalid,      // AXI write data valid
  output logic             wready,      // AXI write data ready
  output logic [1:0]       bresp,       // AXI write response
  output logic             bvalid,      // AXI write response valid
  input  wire logic        bready,      // AXI write response ready
  input  wire logic [11:0] araddr,      // AXI read address
  input  wire logic        arvalid,     // AXI read address valid
  output logic             arready,     // AXI read address ready
  output logic [31:0]      rdata,       // AXI read data
  output logic [1:0]       rresp,       // AXI read response
  output logic             rvalid,      // AXI read valid
  input  wire logic        rready,      // AXI read ready
  output logic [2:0]       outClosed_r  // Output pins, 1 = closed
);
  import sso_pkg::*;

  logic        modeVel;
  logic [15:0] holdMs, zeroWidth, reachThr, fluctRange;
  logic [23:0] funcCodes;
  logic        zeroSpeedFlag, velocityReachedFlag, velocityCoincidentFlag;
  logic        zeroCond, reachCond, coinCond, msTick_r;
  logic [14:0] tickCnt_r;
  logic        awreadyI, wreadyI, arreadyI;

  function automatic logic [15:0] mag(input logic [15:0] v);
    mag = v[15] ? (16'h0000 - v) : v;
  endfunction : mag

  // Readies are flops in the slave, so every output leaves a register
  assign awready = awreadyI;
  assign wready  = wreadyI;
  assign arready = arreadyI;

  sso_axil_regs u_regs (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ce         (ce),
    .awaddr     (awaddr),
    .awvalid    (awvalid),
    .awready    (awreadyI),
    .wdata      (wdata),
    .wstrb      (wstrb),
    .wvalid     (wvalid),
    .wready     (wreadyI),
    .bresp      (bresp),
    .bvalid     (bvalid),
    .bready     (bready),
    .araddr     (araddr),
    .arvalid    (arvalid),
    .arready    (arreadyI),
    .rdata      (rdata),
    .rresp      (rresp),
    .rvalid     (rvalid),
    .rready     (rready),
    .flags      ({velocityCoincidentFlag, velocityReachedFlag, zeroSpeedFlag}),
    .modeVel    (modeVel),
    .holdMs     (holdMs),
    .zeroWidth  (zeroWidth),
    .reachThr   (reachThr),
    .fluctRange (fluctRange),
    .funcCodes  (funcCodes)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tickCnt_r <= 15'h0000;
      msTick_r  <= 1'b0;
    end else if (ce) begin
      msTick_r  <= (tickCnt_r == 15'(TICK_CYCLES - 1));
      tickCnt_r <= (tickCnt_r == 15'(TICK_CYCLES - 1)) ? 15'h0000 : tickCnt_r + 15'h0001;
    end
  end

  assign zeroCond  = mag(actSpeed) <= zeroWidth;
  // Reached needs both raw and filtered above
  assign reachCond = modeVel && (mag(actSpeed) > reachThr) && (mag(filtSpeed) > reachThr);
  assign coinCond  = modeVel && (mag(16'(actSpeed - cmdSpeed)) <= fluctRange);

  sso_qual_timer u_zero (.mclk(mclk), .rst_n(rst_n), .ce(ce), .msTick(msTick_r), .cond(zeroCond),
                         .holdMs(holdMs), .flag(zeroSpeedFlag));
  sso_qual_timer u_reach (.mclk(mclk), .rst_n(rst_n), .ce(ce), .msTick(msTick_r), .cond(reachCond),
                          .holdMs(holdMs), .flag(velocityReachedFlag));
  sso_qual_timer u_coin (.mclk(mclk), .rst_n(rst_n), .ce(ce), .msTick(msTick_r), .cond(coinCond),
                         .holdMs(holdMs), .flag(velocityCoincidentFlag));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      outClosed_r <= 3'b000;
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        case (funcCodes[8*i +: 8])
          `SSO_FN_ZS_ON:  outClosed_r[i] <= zeroSpeedFlag;
          `SSO_FN_ZS_OFF: outClosed_r[i] <= !zeroSpeedFlag;
          `SSO_FN_VR_ON:  outClosed_r[i] <= velocityReachedFlag;
          `SSO_FN_VR_INV: outClosed_r[i] <= !velocityReachedFlag;
          `SSO_FN_VC_ON:  outClosed_r[i] <= velocityCoincidentFlag;
          `SSO_FN_VC_OFF: outClosed_r[i] <= !velocityCoincidentFlag;
          default:        outClosed_r[i] <= 1'b0;
        endcase
      end
    end
  end

  zero_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && (mag(actSpeed) > zeroWidth) |=> !zeroSpeedFlag) else $error("zero flag kept above width");
  reach_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && (mag(filtSpeed) <= reachThr) |=> !velocityReachedFlag) else $error("reached kept");
  coin_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !coinCond |=> !velocityCoincidentFlag) else $error("coincident kept");
  zero_now_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && holdMs == 16'h0000 && zeroCond |=> zeroSpeedFlag) else $error("zero time not immediate");
  pin_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && funcCodes[7:0] == `SSO_FN_ZS_ON |=> outClosed_r[0] == $past(zeroSpeedFlag)) else $error("pin map");
  pin_unused_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && funcCodes[15:8] == 8'h00 |=> !outClosed_r[1]) else $error("unassigned pin closed");
  mode_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !modeVel |=> !velocityReachedFlag) else $error("reached outside velocity mode");
  width_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
    zeroWidth >= `SSO_ZW_MIN && zeroWidth <= `SSO_ZW_MAX) else $error("width out of range");
endmodule : sso_speed_status

/* test/sso_pin_monitor.sv */
`timescale 1ns/1ps
// Far-side controller: sees only the pin levels, one sample per clock
module sso_pin_monitor (
  input  wire logic       mclk,   // Control clock
  input  wire logic [2:0] pins,   // Drive outputs, 1 = closed
  output logic      [2:0] seen_r  // Levels as the controller last saw them
);
  always_ff @(posedge mclk) begin
    seen_r <= pins;
  end
endmodule : sso_pin_monitor

/* test/sso_speed_status_bench.sv */
`timescale 1ns/1ps
`include "sso_consts.svh"
module sso_speed_status_bench;
  import sso_pkg::*;
  typedef struct {logic [15:0] act, filt, cmd; logic [2:0] exp;} sso_row_t;
  logic        mclk, rst_n, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [15:0] actSpeed, filtSpeed, cmdSpeed;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [2:0]  outClosed_r, seen;
  int          n_fail, n_compared, k;
  // Bits are {coincident, reached, zero}; defaults width 5, threshold 100, range 2
  sso_row_t rows[7] = '{'{16'h0000, 16'h0000, 16'h0000, 3'b101}, '{16'h0005, 16'h0005, 16'h0000, 3'b001},
    '{16'h0006, 16'h0006, 16'h0006, 3'b100}, '{16'hFFFB, 16'hFFFB, 16'hFFFC, 3'b101},
    '{16'h0065, 16'h0065, 16'h0064, 3'b110}, '{16'h0065, 16'h0064, 16'h0065, 3'b100},
    '{16'hFF38, 16'hFF38, 16'hFF3B, 3'b010}};

  sso_speed_status #(.TICK_CYCLES(4)) u_sso_speed_status (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .actSpeed(actSpeed), .filtSpeed(filtSpeed), .cmdSpeed(cmdSpeed), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .outClosed_r(outClosed_r));
  sso_pin_monitor u_sso_pin_monitor (.mclk(mclk), .pins(outClosed_r), .seen_r(seen));

  always #20 mclk = ~mclk;

  task complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Called just after an edge; ends one edge past the answer so no signal is driven twice at once
  task axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    int   n;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (b && n < 60) begin
      @(posedge mclk);
      n++;
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        b = 1'b0;
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (b) check("write answer", 1, 0);
    @(posedge mclk);
  endtask : axiWrite

  task axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rr;
    int   n;
    ar = 1'b1;
    rr = 1'b1;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rr && n < 60) begin
      @(posedge mclk);
      n++;
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        rr = 1'b0;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    if (rr) check("read answer", 1, 0);
    @(posedge mclk);
  endtask : axiRead

  task setSpeed(input logic [15:0] a, input logic [15:0] f, input logic [15:0] c);
    actSpeed <= a;
    filtSpeed <= f;
    cmdSpeed <= c;
  endtask : setSpeed

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    ce = 1'b1;
    {actSpeed, filtSpeed, cmdSpeed} = '0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check("pins unassigned", 3'b000, seen);
    axiWrite(`SSO_OFF_TIME, 32'h0000_0000, rsp);
    for (int p = 0; p < 2; p++) begin
      axiWrite(`SSO_OFF_FUNC, p ? 32'h0012_1422 : 32'h0011_0A16, rsp);
      for (k = 0; k < 7; k++) begin
        setSpeed(rows[k].act, rows[k].filt, rows[k].cmd);
        repeat (4) @(posedge mclk);
        check("pins", p ? 3'(~rows[k].exp) : rows[k].exp, seen);
        axiRead(`SSO_OFF_STATUS, rd, rsp);
        check("status", rows[k].exp, rd);
      end
    end
    $display("test table done");
    axiWrite(`SSO_OFF_CTRL, 32'h0000_0000, rsp);
    setSpeed(16'h0065, 16'h0065, 16'h0064);
    repeat (4) @(posedge mclk);
    axiRead(`SSO_OFF_STATUS, rd, rsp);
    check("status other mode", 3'b000, rd);
    setSpeed(16'h0000, 16'h0000, 16'h0000);
    repeat (4) @(posedge mclk);
    axiRead(`SSO_OFF_STATUS, rd, rsp);
    check("zero other mode", 3'b001, rd);
    $display("test mode done");
    axiWrite(`SSO_OFF_FUNC, 32'h0000_0016, rsp);
    axiWrite(`SSO_OFF_TIME, 32'h0000_0002, rsp);
    setSpeed(16'h0064, 16'h0064, 16'h0000);
    repeat (4) @(posedge mclk);
    setSpeed(16'h0000, 16'h0000, 16'h0000);
    repeat (2) @(posedge mclk);
    check("zero pin early", 1'b0, outClosed_r[0]);
    k = 0;
    while (outClosed_r[0] !== 1'b1 && k < 14) begin
      @(posedge mclk);
      k++;
    end
    check("zero pin in time", 1'b1, outClosed_r[0]);
    // A single lapsed cycle must restart the whole hold
    setSpeed(16'h0064, 16'h0064, 16'h0000);
    @(posedge mclk);
    setSpeed(16'h0000, 16'h0000, 16'h0000);
    repeat (3) @(posedge mclk);
    check("zero pin restarted", 1'b0, outClosed_r[0]);
    // Low enable must freeze the hold count part way
    ce <= 1'b0;
    repeat (12) @(posedge mclk);
    check("zero pin frozen", 1'b0, outClosed_r[0]);
    ce <= 1'b1;
    k = 0;
    while (outClosed_r[0] !== 1'b1 && k < 14) begin
      @(posedge mclk);
      k++;
    end
    check("zero pin resumed", 1'b1, outClosed_r[0]);
    $display("test timer done");
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check("pins after reset", 3'b000, outClosed_r);
    for (k = 0; k < 6; k++) begin
      axiRead(12'(4 * k), rd, rsp);
      check("reset value", k == 0 ? 1 : k == 1 ? 10 : k == 2 ? 5 : k == 3 ? 100 : k == 4 ? 2 : 0, rd);
    end
    axiRead(12'h01C, rd, rsp);
    check("unmapped read", SSO_RESP_SLVERR, rsp);
    axiWrite(12'h020, 32'h0000_0001, rsp);
    check("unmapped write", SSO_RESP_SLVERR, rsp);
    axiWrite(`SSO_OFF_TIME, 32'h0000_9C40, rsp);
    axiRead(`SSO_OFF_TIME, rd, rsp);
    check("hold clamp", 32'h0000_7530, rd);
    $display("test reset done");
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    complete_run();
  end
endmodule : sso_speed_status_bench
